// file: dghs_cfg.svh
/*
 * Constants of the debug group and halt summary block: sizes, register
 * addresses, field positions and reset values.
 * Assumes inclusion by the package and by the block's single design file.
 */
`ifndef DGHS_CFG_SVH
`define DGHS_CFG_SVH

// population behind this debug unit
`define DGHS_NUM_HARTS      8
`define DGHS_NUM_TRIGS      2
`define DGHS_HARTSEL_W      20
`define DGHS_GRP_W          5
`define DGHS_TRIG_W         4
`define DGHS_ADDR_W         7
`define DGHS_DATA_W         32

// group support
`define DGHS_HALT_GRP_IMPL  1'b1
`define DGHS_RES_GRP_IMPL   1'b1
`define DGHS_HALT_GRP_MAX   5'h07
`define DGHS_RES_GRP_MAX    5'h03

// register addresses on the debug module interface
`define DGHS_ADDR_SUM1      7'h13
`define DGHS_ADDR_GCS       7'h32
`define DGHS_ADDR_SUM2      7'h34
`define DGHS_ADDR_SUM3      7'h35
`define DGHS_ADDR_SUM0      7'h40

// group_control_status field positions
`define DGHS_GTYPE_BIT      11
`define DGHS_TRIG_MSB       10
`define DGHS_TRIG_LSB       7
`define DGHS_GRP_MSB        6
`define DGHS_GRP_LSB        2
`define DGHS_HGWRITE_BIT    1
`define DGHS_HGSEL_BIT      0

// reset values
`define DGHS_GRP_RST        5'h00
`define DGHS_TRIG_RST       4'h0
`define DGHS_RDATA_RST      32'h0000_0000

`endif

// file: dghs_pkg.sv
/*
 * Types of the debug group and halt summary block.
 * Assumes dghs_cfg.svh is reachable by its bare name.
 */
`include "dghs_cfg.svh"

package dghs_pkg;

	typedef logic [`DGHS_GRP_W-1:0]                            dghs_grp_t;
	typedef logic [`DGHS_NUM_HARTS-1:0][`DGHS_GRP_W-1:0]       dghs_hart_grps_t;
	typedef logic [`DGHS_NUM_TRIGS-1:0][`DGHS_GRP_W-1:0]       dghs_trig_grps_t;
	typedef logic [`DGHS_NUM_HARTS-1:0]                        dghs_hart_vec_t;
	typedef logic [`DGHS_HARTSEL_W-1:0]                        dghs_hartsel_t;
	typedef logic [`DGHS_ADDR_W-1:0]                           dghs_addr_t;
	typedef logic [`DGHS_DATA_W-1:0]                           dghs_data_t;

	typedef struct packed {
		logic            grouptype;
		logic [`DGHS_TRIG_W-1:0] trig_sel;
		logic            hgselect;
		dghs_hart_grps_t hart_hgrp;
		dghs_hart_grps_t hart_rgrp;
		dghs_trig_grps_t trig_hgrp;
		dghs_trig_grps_t trig_rgrp;
		logic            rsp_valid;
		dghs_data_t      rsp_rdata;
	} dghs_state_t;

endpackage : dghs_pkg

// file: dghs_top.sv
/*
 * Halt/resume group control and hierarchical halt summaries of a debug unit,
 * reached over the debug module interface register port.
 * Assumes HARTSEL and HART_HALTED come from logic on CLK, and that the
 * debugger issues one request per cycle at most and reads group back to check.
 */
`include "dghs_cfg.svh"

// Contract
// (RULE_01) no halt groups: halt group reads zero
// (RULE_02) no resume groups: grouptype stays zero
// (RULE_03) bit 11 picks halt or resume groups
// (RULE_04) bad trigger number becomes valid or zero
// (RULE_05) group reads hart or trigger group
// (RULE_06) group written only with hgwrite set
// (RULE_07) groups contiguous from zero; debugger checks
// (RULE_08) no groups at all: group field zero
// (RULE_09) hgwrite on harts sets selected hart group
// (RULE_10) hgwrite on triggers sets trigger group
// (RULE_11) hgwrite zero changes no assignment
// (RULE_12) no triggers: hgselect tied to zero
// (RULE_13) halt and resume trigger sets separate
// (RULE_14) level0 summary: one bit per hart
// (RULE_15) nonexistent harts count as not halted
// (RULE_16) level1 summary: any halted in 32
// (RULE_17) level2 summary: any halted in 1024
// (RULE_18) level3 summary: any halted in 32768
// (RULE_19) summaries read-only, writes change nothing
// (RULE_20) bits 31:12 of control read zero
// (RULE_21) summaries formed from live halted inputs
module dghs_top (
	// clock and reset
	input  wire logic                      CLK,
	input  wire logic                      ARST_N,
	// debug module interface requests
	input  wire logic                      DMI_VALID,
	input  wire logic                      DMI_WRITE,
	input  wire dghs_pkg::dghs_addr_t      DMI_ADDR,
	input  wire dghs_pkg::dghs_data_t      DMI_WDATA,
	// debug module interface answers
	output logic                           DMI_RVALID,
	output dghs_pkg::dghs_data_t           DMI_RDATA,
	// hart side
	input  wire dghs_pkg::dghs_hartsel_t   HARTSEL,
	input  wire dghs_pkg::dghs_hart_vec_t  HART_HALTED,
	output dghs_pkg::dghs_hart_grps_t      HART_HALT_GROUP,
	output dghs_pkg::dghs_hart_grps_t      HART_RESUME_GROUP,
	// external trigger side
	output dghs_pkg::dghs_trig_grps_t      TRIG_HALT_GROUP,
	output dghs_pkg::dghs_trig_grps_t      TRIG_RESUME_GROUP
);
	import dghs_pkg::*;

	dghs_state_t q;
	dghs_state_t d;

	// request decode, shared by the read and the write paths
	logic req_rd;
	logic req_wr;
	logic hit_gcs;
	logic hit_sum;

	// true for the four read-only summary addresses
	function automatic logic is_summary(input dghs_addr_t a);
		return (a == `DGHS_ADDR_SUM0) || (a == `DGHS_ADDR_SUM1) ||
		       (a == `DGHS_ADDR_SUM2) || (a == `DGHS_ADDR_SUM3);
	endfunction : is_summary

	assign req_rd  = DMI_VALID && !DMI_WRITE;
	assign req_wr  = DMI_VALID && DMI_WRITE;
	// the control register is the only one that holds state
	assign hit_gcs = (DMI_ADDR == `DGHS_ADDR_GCS);
	assign hit_sum = is_summary(DMI_ADDR);

	// control word fields
	function automatic logic field_type(input dghs_data_t w);
		return w[`DGHS_GTYPE_BIT];
	endfunction : field_type

	function automatic logic [`DGHS_TRIG_W-1:0] field_trig(input dghs_data_t w);
		return w[`DGHS_TRIG_MSB:`DGHS_TRIG_LSB];
	endfunction : field_trig

	function automatic dghs_grp_t field_grp(input dghs_data_t w);
		return w[`DGHS_GRP_MSB:`DGHS_GRP_LSB];
	endfunction : field_grp

	// the write strobe is never stored
	function automatic logic field_strobe(input dghs_data_t w);
		return w[`DGHS_HGWRITE_BIT];
	endfunction : field_strobe

	function automatic logic field_sel(input dghs_data_t w);
		return w[`DGHS_HGSEL_BIT];
	endfunction : field_sel

	// true when the index names a hart that exists behind this unit
	function automatic logic hart_exists(input dghs_hartsel_t sel);
		return (int'(sel) < `DGHS_NUM_HARTS);
	endfunction : hart_exists

	// true when the index names an external trigger that exists
	function automatic logic trig_exists(input logic [`DGHS_TRIG_W-1:0] t);
		return (int'(t) < `DGHS_NUM_TRIGS);
	endfunction : trig_exists

	// a nonexistent trigger number becomes trigger zero [RULE_04]
	function automatic logic [`DGHS_TRIG_W-1:0] trig_fix(input logic [`DGHS_TRIG_W-1:0] t);
		logic [`DGHS_TRIG_W-1:0] r;
		r = `DGHS_TRIG_RST;
		if (trig_exists(t))
			r = t;
		return r;
	endfunction : trig_fix

	// halted flags of existing harts only; the rest count as running [RULE_15]
	function automatic logic hart_halted(input dghs_hart_vec_t halted, input int i);
		logic r;
		r = 1'b0;
		if ((i >= 0) && (i < `DGHS_NUM_HARTS))
			r = halted[i];
		return r;
	endfunction : hart_halted

	// level 0: one bit per hart of the 32 sharing sel[19:5] [RULE_14]
	function automatic dghs_data_t sum_level0(input dghs_hartsel_t  sel,
	                                          input dghs_hart_vec_t halted);
		dghs_data_t    s;
		dghs_hartsel_t h;
		s = '0;
		for (int i = 0; i < `DGHS_NUM_HARTS; i++) begin
			h = dghs_hartsel_t'(i);
			if (hart_halted(halted, i) && (h[19:5] == sel[19:5]))
				s[h[4:0]] = 1'b1;
		end
		return s;
	endfunction : sum_level0

	// level 1: any halted in each 32-hart block of sel[19:10] [RULE_16]
	function automatic dghs_data_t sum_level1(input dghs_hartsel_t  sel,
	                                          input dghs_hart_vec_t halted);
		dghs_data_t    s;
		dghs_hartsel_t h;
		s = '0;
		for (int i = 0; i < `DGHS_NUM_HARTS; i++) begin
			h = dghs_hartsel_t'(i);
			if (hart_halted(halted, i) && (h[19:10] == sel[19:10]))
				s[h[9:5]] = 1'b1;
		end
		return s;
	endfunction : sum_level1

	// level 2: any halted in each 1024-hart block of sel[19:15] [RULE_17]
	function automatic dghs_data_t sum_level2(input dghs_hartsel_t  sel,
	                                          input dghs_hart_vec_t halted);
		dghs_data_t    s;
		dghs_hartsel_t h;
		s = '0;
		for (int i = 0; i < `DGHS_NUM_HARTS; i++) begin
			h = dghs_hartsel_t'(i);
			if (hart_halted(halted, i) && (h[19:15] == sel[19:15]))
				s[h[14:10]] = 1'b1;
		end
		return s;
	endfunction : sum_level2

	// level 3: any halted in each 32768-hart block [RULE_18]
	function automatic dghs_data_t sum_level3(input dghs_hart_vec_t halted);
		dghs_data_t    s;
		dghs_hartsel_t h;
		s = '0;
		for (int i = 0; i < `DGHS_NUM_HARTS; i++) begin
			h = dghs_hartsel_t'(i);
			if (hart_halted(halted, i))
				s[h[19:15]] = 1'b1;
		end
		return s;
	endfunction : sum_level3

	// summary word for a read address, formed from the live inputs [RULE_21]
	function automatic dghs_data_t sum_read(input dghs_addr_t     a,
	                                        input dghs_hartsel_t  sel,
	                                        input dghs_hart_vec_t halted);
		dghs_data_t r;
		r = '0;
		case (a)
			`DGHS_ADDR_SUM0: r = sum_level0(sel, halted);
			`DGHS_ADDR_SUM1: r = sum_level1(sel, halted);
			`DGHS_ADDR_SUM2: r = sum_level2(sel, halted);
			`DGHS_ADDR_SUM3: r = sum_level3(halted);
			default:         r = '0;
		endcase
		return r;
	endfunction : sum_read

	// a group is accepted only inside the contiguous supported range
	function automatic logic grp_ok(input logic rtype, input dghs_grp_t g);
		if (rtype)
			return `DGHS_RES_GRP_IMPL && (g <= `DGHS_RES_GRP_MAX);   // [RULE_07]
		else
			return `DGHS_HALT_GRP_IMPL && (g <= `DGHS_HALT_GRP_MAX); // [RULE_07]
	endfunction : grp_ok

	// group field as read back for the current selection
	function automatic dghs_grp_t grp_read(input dghs_state_t s, input dghs_hartsel_t sel);
		dghs_grp_t g;
		g = '0;
		if (s.hgselect) begin
			if (trig_exists(s.trig_sel))
				g = s.grouptype ? s.trig_rgrp[s.trig_sel] : s.trig_hgrp[s.trig_sel];
		end else if (hart_exists(sel)) begin
			g = s.grouptype ? s.hart_rgrp[sel] : s.hart_hgrp[sel];            // [RULE_05]
		end
		if (!s.grouptype && !`DGHS_HALT_GRP_IMPL)
			g = '0;                                                           // [RULE_01]
		if (!`DGHS_HALT_GRP_IMPL && !`DGHS_RES_GRP_IMPL)
			g = '0;                                                           // [RULE_08]
		return g;
	endfunction : grp_read

	// control word as read back; strobe and bits 31:12 read zero [RULE_20]
	function automatic dghs_data_t gcs_word(input dghs_state_t s, input dghs_hartsel_t sel);
		dghs_data_t r;
		r = '0;
		r[`DGHS_GTYPE_BIT]               = s.grouptype;
		r[`DGHS_TRIG_MSB:`DGHS_TRIG_LSB] = s.trig_sel;
		r[`DGHS_GRP_MSB:`DGHS_GRP_LSB]   = grp_read(s, sel);
		r[`DGHS_HGSEL_BIT]               = s.hgselect;
		return r;
	endfunction : gcs_word

	// stores a group for the selected hart in the table the type picks [RULE_09]
	function automatic dghs_state_t store_hart(input dghs_state_t   s,
	                                           input dghs_hartsel_t sel,
	                                           input logic          rtype,
	                                           input dghs_grp_t     g);
		dghs_state_t n;
		n = s;
		if (hart_exists(sel)) begin
			if (rtype)
				n.hart_rgrp[sel] = g;
			else
				n.hart_hgrp[sel] = g;
		end
		return n;
	endfunction : store_hart

	// halt and resume trigger tables are kept apart [RULE_10] [RULE_13]
	function automatic dghs_state_t store_trig(input dghs_state_t             s,
	                                           input logic [`DGHS_TRIG_W-1:0] t,
	                                           input logic                    rtype,
	                                           input dghs_grp_t               g);
		dghs_state_t n;
		n = s;
		if (trig_exists(t)) begin
			if (rtype)
				n.trig_rgrp[t] = g;
			else
				n.trig_hgrp[t] = g;
		end
		return n;
	endfunction : store_trig

	// control write: selectors always taken, the group only with the strobe
	function automatic dghs_state_t gcs_write(input dghs_state_t   s,
	                                          input dghs_data_t    w,
	                                          input dghs_hartsel_t sel);
		dghs_state_t             n;
		logic                    w_type;
		logic                    w_sel;
		logic [`DGHS_TRIG_W-1:0] w_trig;
		dghs_grp_t               w_grp;
		n      = s;
		w_type = `DGHS_RES_GRP_IMPL & field_type(w);          // [RULE_02] [RULE_03]
		w_trig = trig_fix(field_trig(w));                     // [RULE_04]
		w_sel  = (`DGHS_NUM_TRIGS > 0) & field_sel(w);        // [RULE_12]
		w_grp  = field_grp(w);
		// the selectors are written whether or not a group is
		n.grouptype = w_type;
		n.trig_sel  = w_trig;
		n.hgselect  = w_sel;
		// without the strobe the group value is dropped [RULE_06] [RULE_11]
		if (field_strobe(w) && grp_ok(w_type, w_grp)) begin
			if (w_sel)
				n = store_trig(n, w_trig, w_type, w_grp);     // [RULE_10]
			else
				n = store_hart(n, sel, w_type, w_grp);        // [RULE_09]
		end
		return n;
	endfunction : gcs_write

	// one request per cycle; the answer is registered for the next cycle
	always_comb begin
		dghs_data_t rd_word;
		rd_word = '0;
		d = q;
		d.rsp_valid = 1'b0;
		if (req_rd) begin
			if (hit_gcs)
				rd_word = gcs_word(q, HARTSEL);                       // [RULE_05]
			else if (hit_sum)
				rd_word = sum_read(DMI_ADDR, HARTSEL, HART_HALTED);   // [RULE_21]
			else
				rd_word = '0;
			d.rsp_valid = 1'b1;
			d.rsp_rdata = rd_word;
		end else if (req_wr) begin
			// a write leaves the last read data in place
			d.rsp_valid = 1'b1;
			// only the control register holds state; summaries ignore writes [RULE_19]
			if (hit_gcs)
				d = gcs_write(d, DMI_WDATA, HARTSEL);
		end
	end

	// state registers; every output is taken straight from them
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			// every field starts cleared
			q.grouptype <= 1'b0;
			q.trig_sel  <= `DGHS_TRIG_RST;
			q.hgselect  <= 1'b0;
			q.hart_hgrp <= '0;
			q.hart_rgrp <= '0;
			q.trig_hgrp <= '0;
			q.trig_rgrp <= '0;
			q.rsp_valid <= 1'b0;
			q.rsp_rdata <= `DGHS_RDATA_RST;
		end else begin
			q <= d;
		end
	end

	assign DMI_RVALID        = q.rsp_valid;
	assign DMI_RDATA         = q.rsp_rdata;
	assign HART_HALT_GROUP   = q.hart_hgrp;
	assign HART_RESUME_GROUP = q.hart_rgrp;
	assign TRIG_HALT_GROUP   = q.trig_hgrp;
	assign TRIG_RESUME_GROUP = q.trig_rgrp;

endmodule : dghs_top

// file: dghs_properties.sv
/* assertions on the ports of dghs_top; assumes one clock and async reset */
module dghs_properties
	import dghs_pkg::*;
(
	// clock and reset
	input wire logic		CLK,
	input wire logic		ARST_N,
	// register port
	input wire logic		DMI_VALID,
	input wire logic		DMI_WRITE,
	input wire dghs_addr_t		DMI_ADDR,
	input wire dghs_data_t		DMI_WDATA,
	input wire dghs_data_t		DMI_RDATA,
	// hart and trigger side
	input wire dghs_hartsel_t	HARTSEL,
	input wire dghs_hart_vec_t	HART_HALTED,
	input wire dghs_hart_grps_t	HART_HALT_GROUP,
	input wire dghs_trig_grps_t	TRIG_HALT_GROUP
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	wire logic rd = DMI_VALID && !DMI_WRITE;
	wire logic wr = DMI_VALID && DMI_WRITE;
	a_ctrl_hi_zero: assert property (rd && DMI_ADDR == 7'h32 |=> DMI_RDATA[31:12] == 20'h0)
		else $error("control upper bits set");
	a_sum0_bits: assert property (rd && DMI_ADDR == 7'h40 |=>
		DMI_RDATA == ($past(HARTSEL[19:5]) == 15'h0 ? {24'h0, $past(HART_HALTED)} : 32'h0))
		else $error("level0 summary wrong");
	a_sum1_any: assert property (rd && DMI_ADDR == 7'h13 |=>
		DMI_RDATA == {31'h0, $past(HARTSEL[19:10] == 10'h0 && |HART_HALTED)})
		else $error("level1 summary wrong");
	a_sum2_any: assert property (rd && DMI_ADDR == 7'h34 |=>
		DMI_RDATA == {31'h0, $past(HARTSEL[19:15] == 5'h0 && |HART_HALTED)})
		else $error("level2 summary wrong");
	a_sum3_any: assert property (rd && DMI_ADDR == 7'h35 |=>
		DMI_RDATA == {31'h0, $past(|HART_HALTED)})
		else $error("level3 summary wrong");
	a_keep_no_strobe: assert property (wr && !DMI_WDATA[1] |=>
		$stable(HART_HALT_GROUP) && $stable(TRIG_HALT_GROUP))
		else $error("group changed without strobe");
	a_sum_read_only: assert property (wr && DMI_ADDR != 7'h32 |=>
		$stable(HART_HALT_GROUP) && $stable(TRIG_HALT_GROUP))
		else $error("group changed by other write");
	a_hart_grp_set: assert property (wr && DMI_ADDR == 7'h32 && DMI_WDATA[1] &&
		!DMI_WDATA[0] && !DMI_WDATA[11] && DMI_WDATA[6:5] == 2'h0 && HARTSEL < 20'h8 |=>
		HART_HALT_GROUP[$past(HARTSEL[2:0])] == $past(DMI_WDATA[6:2]))
		else $error("hart halt group not stored");
endmodule : dghs_properties

bind dghs_top dghs_properties u_props (.*);

// file: dghs_dbg_model.sv
/* debugger side of the register port; assumes requests launched at falling edges */
module dghs_dbg_model
	import dghs_pkg::*;
(
	// clock
	input wire logic	clk,
	// requests
	output logic		dmi_valid,
	output logic		dmi_write,
	output dghs_addr_t	dmi_addr,
	output dghs_data_t	dmi_wdata,
	// answers
	input wire logic	dmi_rvalid,
	input wire dghs_data_t	dmi_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		dmi_valid = 1'b0;
		dmi_write = 1'b0;
		dmi_addr = 7'h00;
		dmi_wdata = 32'h0;
	end
	// one request, answer taken half a cycle after the taking edge, at the next falling edge
	task automatic xfer(input logic w, input dghs_addr_t a, input dghs_data_t d,
		output dghs_data_t q);
		@(negedge clk);
		dmi_valid = 1'b1;
		dmi_write = w;
		dmi_addr = a;
		dmi_wdata = d;
		@(negedge clk);
		q = dmi_rvalid === 1'b1 ? dmi_rdata : 32'hBAD0_BAD0;
		dmi_valid = 1'b0;
		dmi_wdata = ~d;
	endtask : xfer
endmodule : dghs_dbg_model

// file: debug_group_and_halt_summary_tb_top.sv
/* register-level tests of dghs_top; assumes dghs_dbg_model as the debugger */
module debug_group_and_halt_summary_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dghs_pkg::*;
	logic			clk = 1'b0;
	logic			arst_n = 1'b0;
	logic			valid, write, rvalid;
	dghs_addr_t		addr;
	dghs_data_t		wdata, rdata, q;
	dghs_hartsel_t		hartsel = 20'h0;
	dghs_hart_vec_t		halted = 8'h00;
	dghs_hart_grps_t	hg, rg;
	dghs_trig_grps_t	tg, tr;
	dghs_hartsel_t		sel[4] = '{20'h0, 20'h20, 20'h400, 20'h8000};
	int			err_total = 0;
	int			compares = 0;
	always #2.5 clk = ~clk;
	dghs_top u_dut (.CLK(clk), .ARST_N(arst_n), .DMI_VALID(valid), .DMI_WRITE(write),
		.DMI_ADDR(addr), .DMI_WDATA(wdata), .DMI_RVALID(rvalid), .DMI_RDATA(rdata),
		.HARTSEL(hartsel), .HART_HALTED(halted), .HART_HALT_GROUP(hg),
		.HART_RESUME_GROUP(rg), .TRIG_HALT_GROUP(tg), .TRIG_RESUME_GROUP(tr));
	dghs_dbg_model u_dbg (.clk(clk), .dmi_valid(valid), .dmi_write(write), .dmi_addr(addr),
		.dmi_wdata(wdata), .dmi_rvalid(rvalid), .dmi_rdata(rdata));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk
	task automatic rd(input dghs_addr_t a, input logic [31:0] e);
		u_dbg.xfer(1'b0, a, 32'h0, q);
		chk("read data", e, q);
	endtask : rd
	task automatic wr(input dghs_addr_t a, input dghs_data_t d);
		u_dbg.xfer(1'b1, a, d, q);
		chk("write answer", 32'h1, 32'(rvalid));
	endtask : wr
	task automatic finish_test;
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	initial begin
		#20000;
		err_total++;
		finish_test();
	end
	initial begin
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		rd(7'h32, 32'h0);
		rd(7'h00, 32'h0);
		halted = 8'hA5;
		for (int k = 0; k < 4; k++) begin
			hartsel = sel[k];
			rd(7'h40, k == 0 ? 32'hA5 : 32'h0);
			rd(7'h13, {31'h0, k < 2});
			rd(7'h34, {31'h0, k < 3});
			rd(7'h35, 32'h1);
		end
		halted = 8'h00;
		rd(7'h35, 32'h0);
		for (int h = 0; h < 8; h++) begin
			hartsel = 20'(h);
			wr(7'h32, 32'(h * 4 + 2));
			rd(7'h32, 32'(h * 4));
			chk("hart halt group", 32'(h), 32'(hg[h]));
		end
		hartsel = 20'h1;
		wr(7'h32, 32'h7C);
		wr(7'h32, 32'h22);
		rd(7'h32, 32'h4);
		wr(7'h40, 32'hFFFF_FFFF);
		wr(7'h13, 32'hFFFF_FFFF);
		rd(7'h32, 32'h4);
		hartsel = 20'h2;
		wr(7'h32, 32'h80E);
		chk("hart resume group", 32'h3, 32'(rg[2]));
		chk("hart halt group", 32'h2, 32'(hg[2]));
		rd(7'h32, 32'h80C);
		wr(7'h32, 32'h9B);
		chk("trigger halt group", 32'h6, 32'(tg[1]));
		wr(7'h32, 32'h781);
		rd(7'h32, 32'h1);
		wr(7'h32, 32'h80B);
		chk("trigger resume group", 32'h2, 32'(tr[0]));
		chk("trigger halt group", 32'h0, 32'(tg[0]));
		finish_test();
	end
endmodule : debug_group_and_halt_summary_tb_top
